// *** core/i2t_port.sv ***
// Two-wire bus target port giving byte access to a register space.
// Assumes scl and sda come from pins; backup state and register space
// share clk_i. SDA is open drain: only the enable toggles.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// How it works
// - answer only address 1010010b
// - address MSB first, eighth bit selects read
// - read/write bit fixes direction until end
// - foreign address: no acknowledge, ignore transfer
// - stop or new start ends a write
// - first written byte loads pointer
// - pointer advances after each data byte taken into the write buffer
// - acknowledge address, pointer and data bytes, data only while the write buffer has room
// - addressed read starts at loaded pointer
// - plain read sends last register plus one
// - pointer advances as each byte is fetched for sending
// - on missing acknowledge release the data line
// - backup supply: released and held in reset
// - 950 ms transaction timeout returns to idle
// - after timeout reads give all ones
// - pointer survives stop and timeout
module i2t_port
   import i2t_pkg::*;
#(
   parameter logic [TMO_W-1:0] TMO_LIMIT = TMO_W'(TMO_CYC)
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   input wire logic backup_supply_state_i,
   output logic wr_valid_o,
   input wire logic wr_ready_i,
   output logic [7:0] wr_ptr_o,
   output logic [7:0] wr_data_o,
   output logic rd_stb_o,
   output logic [7:0] rd_ptr_o,
   input wire logic [7:0] rd_data_i
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic scl_s1_r, scl_s2_r, scl_s3_r, sda_s1_r, sda_s2_r, sda_s3_r;
   logic rise, fall, start_s, stop_s, tmo_hit;
   i2t_st_t st_r, st_nxt, nx_r, nx_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   logic [6:0] sh_r, sh_nxt;
   logic [7:0] tx_r, tx_nxt, ptr_r, ptr_nxt, rxb;
   logic drv_r, drv_nxt, ack_r, ack_nxt, ph_r, ph_nxt, dir_r, dir_nxt;
   logic [TMO_W-1:0] tmo_r, tmo_nxt;
   logic push, buf_rdy;
   logic [BUF_W-1:0] buf_out;

   function automatic logic [7:0] inc8(input logic [7:0] v);
      return v + 8'h01;
   endfunction : inc8

   ////////////////////////////////////////////////////////////////////////////
   // Bus line synchronisers and edge and condition detection
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_s3_r <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_s3_r <= 1'b1;
      end else begin
         scl_s1_r <= scl_i;
         scl_s2_r <= scl_s1_r;
         scl_s3_r <= scl_s2_r;
         sda_s1_r <= sda_i;
         sda_s2_r <= sda_s1_r;
         sda_s3_r <= sda_s2_r;
      end
   end

   // Conditions: data moves while clock is high
   assign rise = scl_s2_r && !scl_s3_r;
   assign fall = !scl_s2_r && scl_s3_r;
   assign start_s = scl_s2_r && scl_s3_r && sda_s3_r && !sda_s2_r;
   assign stop_s = scl_s2_r && scl_s3_r && !sda_s3_r && sda_s2_r;
   assign rxb = {sh_r, sda_s2_r};
   assign tmo_hit = (tmo_r == TMO_LIMIT - 1'b1);

   ////////////////////////////////////////////////////////////////////////////
   // Protocol engine: next values
   always_comb begin
      st_nxt = st_r;
      nx_nxt = nx_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      tx_nxt = tx_r;
      ptr_nxt = ptr_r;
      drv_nxt = drv_r;
      ack_nxt = ack_r;
      ph_nxt = ph_r;
      dir_nxt = dir_r;
      push = 1'b0;
      rd_stb_o = 1'b0;
      tmo_nxt = (st_r == ST_IDLE) ? '0 : tmo_r + 1'b1;
      if (rise) begin
         unique case (st_r)
            ST_ADDR, ST_PTR, ST_WDATA: begin
               sh_nxt = rxb[6:0];
               cnt_nxt = cnt_r + 3'h1;
               if (cnt_r == BIT_LAST) begin
                  st_nxt = ST_ACK;
                  ph_nxt = 1'b0;
                  ack_nxt = 1'b1;
                  nx_nxt = ST_WDATA;
                  if (st_r == ST_ADDR) begin
                     if (rxb[7:1] != DEV_ADDR) begin
                        st_nxt = ST_IDLE;
                     end else if (rxb[0]) begin
                        // Prefetch the first byte at the current pointer
                        dir_nxt = 1'b1;
                        rd_stb_o = 1'b1;
                        tx_nxt = rd_data_i;
                        ptr_nxt = inc8(ptr_r);
                        nx_nxt = ST_RDATA;
                     end else begin
                        dir_nxt = 1'b0;
                        nx_nxt = ST_PTR;
                     end
                  end else if (st_r == ST_PTR) begin
                     ptr_nxt = rxb;
                  end else if (buf_rdy) begin
                     push = 1'b1;
                     ptr_nxt = inc8(ptr_r);
                  end else begin
                     ack_nxt = 1'b0; // Full buffer refuses the byte
                  end
               end
            end
            ST_RDATA: begin
               cnt_nxt = cnt_r + 3'h1;
               if (cnt_r == BIT_LAST) begin
                  st_nxt = ST_RACK;
               end
            end
            ST_RACK: begin
               if (sda_s2_r) begin
                  st_nxt = ST_IDLE;
               end else begin
                  rd_stb_o = 1'b1;
                  tx_nxt = rd_data_i;
                  ptr_nxt = inc8(ptr_r);
                  cnt_nxt = 3'h0;
                  st_nxt = ST_RDATA;
               end
            end
            default: begin
            end
         endcase
      end else if (fall) begin
         unique case (st_r)
            ST_ACK: begin
               if (!ph_r) begin
                  drv_nxt = ack_r;
                  ph_nxt = 1'b1;
               end else begin
                  ph_nxt = 1'b0;
                  st_nxt = nx_r;
                  cnt_nxt = 3'h0;
                  drv_nxt = (nx_r == ST_RDATA) ? !tx_r[7] : 1'b0;
                  if (nx_r == ST_RDATA) begin
                     tx_nxt = {tx_r[6:0], 1'b1};
                  end
               end
            end
            ST_RDATA: begin
               drv_nxt = !tx_r[7];
               tx_nxt = {tx_r[6:0], 1'b1};
            end
            ST_RACK: begin
               drv_nxt = 1'b0;
            end
            default: begin
            end
         endcase
      end
      // Released line reads as FFh and writes go unacknowledged
      if (stop_s || (tmo_hit && st_r != ST_IDLE)) begin
         st_nxt = ST_IDLE;
         drv_nxt = 1'b0;
      end
      if (start_s) begin
         st_nxt = ST_ADDR;
         cnt_nxt = 3'h0;
         drv_nxt = 1'b0;
         tmo_nxt = '0;
      end
      if (backup_supply_state_i) begin
         st_nxt = ST_IDLE;
         drv_nxt = 1'b0;
         ptr_nxt = PTR_RST;
         tmo_nxt = '0;
         push = 1'b0;
         rd_stb_o = 1'b0;
      end
   end

   // Protocol engine: registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= ST_IDLE;
         nx_r <= ST_IDLE;
         cnt_r <= 3'h0;
         sh_r <= 7'h00;
         tx_r <= 8'hFF;
         ptr_r <= PTR_RST;
         drv_r <= 1'b0;
         ack_r <= 1'b0;
         ph_r <= 1'b0;
         dir_r <= 1'b0;
         tmo_r <= '0;
      end else begin
         st_r <= st_nxt;
         nx_r <= nx_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         tx_r <= tx_nxt;
         ptr_r <= ptr_nxt;
         drv_r <= drv_nxt;
         ack_r <= ack_nxt;
         ph_r <= ph_nxt;
         dir_r <= dir_nxt;
         tmo_r <= tmo_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin and register-space outputs
   assign sda_o = 1'b0;
   assign sda_oe_n_o = !drv_r || backup_supply_state_i;
   assign rd_ptr_o = ptr_r;
   assign wr_ptr_o = buf_out[15:8];
   assign wr_data_o = buf_out[7:0];

   // Write words wait here while the register space stalls
   i2t_buf u_buf (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(push),
      .in_ready_o(buf_rdy),
      .in_data_i({ptr_r, rxb}),
      .out_valid_o(wr_valid_o),
      .out_ready_i(wr_ready_i),
      .out_data_o(buf_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   addr_match_a: assert property (
      (rise && st_r == ST_ADDR && cnt_r == BIT_LAST && rxb[7:1] == DEV_ADDR
       && !stop_s && !backup_supply_state_i) |=> st_r == ST_ACK && ack_r)
      else $error("own address not acknowledged");
   addr_miss_a: assert property (
      (rise && st_r == ST_ADDR && cnt_r == BIT_LAST && rxb[7:1] != DEV_ADDR)
      |=> st_r == ST_IDLE && !drv_r)
      else $error("foreign address answered");
   rd_dir_a: assert property ((st_r == ST_RDATA) |-> dir_r)
      else $error("read data in write direction");
   stop_idle_a: assert property (stop_s && !start_s |=> st_r == ST_IDLE)
      else $error("stop did not end transfer");
   ptr_load_a: assert property (
      (rise && st_r == ST_PTR && cnt_r == BIT_LAST && !backup_supply_state_i)
      |=> ptr_r == $past(rxb))
      else $error("pointer byte not loaded");
   wr_inc_a: assert property (push |=> ptr_r == $past(ptr_r) + 8'h01)
      else $error("pointer not advanced after write");
   rd_inc_a: assert property (
      rd_stb_o |=> ptr_r == $past(ptr_r) + 8'h01 && tx_r == $past(rd_data_i))
      else $error("read byte or pointer step wrong");
   nack_rel_a: assert property (
      (rise && st_r == ST_RACK && sda_s2_r) |=> !drv_r ##1 sda_oe_n_o)
      else $error("line held after missing acknowledge");
   backup_off_a: assert property (
      backup_supply_state_i |-> sda_oe_n_o ##1 (st_r == ST_IDLE && ptr_r == PTR_RST))
      else $error("port active in backup supply");
   tmo_idle_a: assert property (
      (tmo_hit && st_r != ST_IDLE && !start_s) |=> st_r == ST_IDLE && !drv_r)
      else $error("timeout did not clear port");
   ptr_keep_a: assert property (
      (stop_s && !backup_supply_state_i) |=> $stable(ptr_r))
      else $error("pointer changed at stop");

   wr_c: cover property (push ##[1:200] stop_s);
   rd_nack_c: cover property (rise && st_r == ST_RACK && sda_s2_r);
   tmo_c: cover property (tmo_hit && st_r != ST_IDLE);
   miss_c: cover property (rise && st_r == ST_ADDR && cnt_r == BIT_LAST
      && rxb[7:1] != DEV_ADDR);

endmodule : i2t_port

// *** shared/i2t_pkg.sv ***
// Shared constants and types of the two-wire target register port.
// Assumes a 10 MHz core clock; the link clock is sampled, not used as a clock.
package i2t_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus address and pointer
   localparam logic [6:0] DEV_ADDR = 7'h52; // 1010010b: A4h write, A5h read
   localparam logic [7:0] PTR_RST = 8'h00;
   localparam logic [2:0] BIT_LAST = 3'h7;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int unsigned CLK_KHZ = 10000;
   localparam int unsigned TMO_MS = 950;
   localparam int unsigned TMO_CYC = TMO_MS * CLK_KHZ;
   localparam int TMO_W = 24;

   ////////////////////////////////////////////////////////////////////////////
   // Write buffer: pointer in the high byte, data in the low byte
   localparam int BUF_W = 16;
   localparam logic [1:0] BUF_D = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Protocol states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_PTR = 3'b010,
      ST_WDATA = 3'b011,
      ST_RDATA = 3'b100,
      ST_RACK = 3'b101,
      ST_ACK = 3'b110
   } i2t_st_t;

endpackage : i2t_pkg

// *** core/i2t_buf.sv ***
// Two-entry buffer between the bus side and the register space.
// Assumes both sides run on clk_i; a stalled drain makes it fill.
`timescale 1ns/1ns
module i2t_buf
   import i2t_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [BUF_W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [BUF_W-1:0] out_data_o
);

   logic [BUF_W-1:0] mem_r [2];
   logic [BUF_W-1:0] mem_nxt [2];
   logic wp_r, wp_nxt, rp_r, rp_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic push, pop;

   ////////////////////////////////////////////////////////////////////////////
   // Handshakes and next state
   assign in_ready_o = (cnt_r != BUF_D);
   assign out_valid_o = (cnt_r != 2'h0);
   assign out_data_o = mem_r[rp_r];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb begin
      mem_nxt = mem_r;
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      cnt_nxt = cnt_r;
      if (push) begin
         mem_nxt[wp_r] = in_data_i;
         wp_nxt = ~wp_r;
      end
      if (pop) begin
         rp_nxt = ~rp_r;
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + 2'h1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 2'h1;
      end
   end

   // Storage and pointers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mem_r <= '{default: '0};
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
      end else begin
         mem_r <= mem_nxt;
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   full_hold_a: assert property (
      (cnt_r == BUF_D && !out_ready_i) |=> (cnt_r == BUF_D) && !in_ready_o)
      else $error("buffer lost or accepted a word while full");
   first_out_a: assert property (
      (push && cnt_r == 2'h0) |=> out_valid_o && out_data_o == $past(in_data_i))
      else $error("buffer head differs from first word in");
   fill_c: cover property (cnt_r == BUF_D);

endmodule : i2t_buf

// *** verif/i2t_ctl_model.sv ***
// Behavioural two-wire bus controller that drives the target port.
// Assumes the bench resolves the data wire from both open-drain enables.
`timescale 1ns/1ns
module i2t_ctl_model (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_oe_n_o
);

   ////////////////////////////////////////////////////////////
   // Bus idle: both lines released, clock stands still
   initial begin
      scl_o = 1'b1;
      sda_oe_n_o = 1'b1;
   end

   // Set clock and data enable at an edge, then hold for n cycles
   task automatic phase(input logic c, input logic e, input int n);
      scl_o <= c;
      sda_oe_n_o <= e;
      repeat (n) @(posedge clk_i);
   endtask : phase

   // One bit: data set in the low half, sampled late in the high half
   task automatic bit_io(input logic b, output logic s);
      phase(1'b0, sda_oe_n_o, 1);
      phase(1'b0, b, 3);
      phase(1'b1, b, 3);
      s = sda_i;
      phase(1'b1, b, 1);
   endtask : bit_io

   ////////////////////////////////////////////////////////////
   // Start or repeated start: data falls while clock is high
   task automatic start_cond();
      phase(1'b0, sda_oe_n_o, 1);
      phase(1'b0, 1'b1, 3);
      phase(1'b1, 1'b1, 4);
      phase(1'b1, 1'b0, 4);
      phase(1'b0, 1'b0, 4);
   endtask : start_cond

   // Stop: data rises while clock is high, bus left idle
   task automatic stop_cond();
      phase(1'b0, sda_oe_n_o, 1);
      phase(1'b0, 1'b0, 3);
      phase(1'b1, 1'b0, 4);
      phase(1'b1, 1'b1, 4);
   endtask : stop_cond

   // Byte out, most significant bit first; ninth clock reads acknowledge
   task automatic send_byte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(v[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask : send_byte

   // Byte in; acknowledge all but the last byte of a burst
   task automatic recv_byte(input logic ack, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         v[i] = s;
      end
      bit_io(~ack, s);
   endtask : recv_byte

endmodule : i2t_ctl_model

// *** verif/testbench.sv ***
// Self-checking bench of the two-wire target register port.
// Assumes i2t_ctl_model as controller and a pull-up on the data wire.
`timescale 1ns/1ns
module testbench;
   import i2t_pkg::*;

   typedef struct packed {
      logic [7:0] addr;
      logic ack;
   } i2t_row_t;

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic backup = 1'b0;
   logic wr_ready = 1'b1;
   logic scl;
   logic ctl_oe_n;
   logic dut_oe_n;
   logic sda_wire;
   logic wr_valid;
   logic [7:0] wr_ptr;
   logic [7:0] wr_data;
   logic [7:0] rd_ptr;
   logic [7:0] rd_data;
   logic a;
   logic [7:0] d;
   logic rd_stb;
   logic sda_lvl;
   int stb_count = 0;
   int stb_mark;
   int bad_count = 0;
   int checked = 0;
   i2t_row_t rows [8] = '{'{8'hA4, 1'b1}, '{8'hA5, 1'b1}, '{8'hA6, 1'b0}, '{8'h24, 1'b0},
      '{8'h25, 1'b0}, '{8'h84, 1'b0}, '{8'hAC, 1'b0}, '{8'hA0, 1'b0}};

   ////////////////////////////////////////////////////////////
   // Clock, wire resolution and register space (value = pointer ^ 5Ah)
   always #50 clk = ~clk;
   assign sda_wire = ctl_oe_n & dut_oe_n;
   assign rd_data = rd_ptr ^ 8'h5A;

   // Read strobes seen by the register space
   always @(posedge clk) begin
      if (rd_stb === 1'b1) begin
         stb_count <= stb_count + 1;
      end
   end

   i2t_port #(.TMO_LIMIT(24'h0007D0)) i_dut (
      .clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda_wire), .sda_o(sda_lvl),
      .sda_oe_n_o(dut_oe_n), .backup_supply_state_i(backup), .wr_valid_o(wr_valid),
      .wr_ready_i(wr_ready), .wr_ptr_o(wr_ptr), .wr_data_o(wr_data), .rd_stb_o(rd_stb),
      .rd_ptr_o(rd_ptr), .rd_data_i(rd_data));

   i2t_ctl_model i_ctl (.clk_i(clk), .sda_i(sda_wire), .scl_o(scl), .sda_oe_n_o(ctl_oe_n));

   ////////////////////////////////////////////////////////////
   // Compare tasks and verdict
   task automatic chk1(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t flag got %b exp %b", $time, got, exp);
      end
   endtask : chk1

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t byte got %h exp %h", $time, got, exp);
      end
   endtask : chk8

   task automatic summarize();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize

   // Byte to the target with expected acknowledge
   task automatic wb(input logic [7:0] v, input logic exp);
      i_ctl.send_byte(v, a);
      chk1(a, exp);
   endtask : wb

   // Byte from the target with expected value
   task automatic rb(input logic [7:0] exp, input logic ack);
      i_ctl.recv_byte(ack, d);
      chk8(d, exp);
   endtask : rb

   // Take one word from the write buffer, bounded wait
   task automatic take(input logic [7:0] p, input logic [7:0] v);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (wr_valid !== 1'b1 && n < 50);
      chk1(wr_valid, 1'b1);
      chk8(wr_ptr, p);
      chk8(wr_data, v);
      if (n >= 50) begin
         summarize();
      end else begin
         @(posedge clk);
      end
   endtask : take

   // Hang guard
   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      summarize();
   end

   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk1(dut_oe_n, 1'b1);
      chk1(wr_valid, 1'b0);
      chk8(rd_ptr, 8'h00);
      chk1(sda_lvl, 1'b0);
      repeat (4) @(posedge clk);
      // Address table: own address answered, others ignored
      foreach (rows[i]) begin
         i_ctl.start_cond();
         wb(rows[i].addr, rows[i].ack);
         if (rows[i].ack && rows[i].addr[0]) begin
            rb(8'h5A, 1'b0);
         end else if (!rows[i].ack) begin
            wb(8'h00, 1'b0);
         end
         i_ctl.stop_cond();
      end
      // Write burst into a stalled register space; third data byte refused
      wr_ready <= 1'b0;
      i_ctl.start_cond();
      wb(8'hA4, 1'b1);
      wb(8'h10, 1'b1);
      wb(8'h3C, 1'b1);
      wb(8'hC3, 1'b1);
      wb(8'h77, 1'b0);
      i_ctl.stop_cond();
      wr_ready <= 1'b1;
      take(8'h10, 8'h3C);
      take(8'h11, 8'hC3);
      repeat (2) @(negedge clk);
      chk1(wr_valid, 1'b0);
      chk8(rd_ptr, 8'h12);
      @(posedge clk);
      // Addressed read through a repeated start
      stb_mark = stb_count;
      i_ctl.start_cond();
      wb(8'hA4, 1'b1);
      wb(8'h20, 1'b1);
      i_ctl.start_cond();
      wb(8'hA5, 1'b1);
      rb(8'h7A, 1'b1);
      rb(8'h7B, 1'b0);
      i_ctl.stop_cond();
      chk1(sda_wire, 1'b1);
      chk8(8'(stb_count - stb_mark), 8'h02);
      // Current-address read continues after the last register
      i_ctl.start_cond();
      wb(8'hA5, 1'b1);
      rb(8'h78, 1'b0);
      i_ctl.stop_cond();
      chk8(rd_ptr, 8'h23);
      // Transaction timeout during a write, then during a read
      i_ctl.start_cond();
      wb(8'hA4, 1'b1);
      repeat (2100) @(posedge clk);
      wb(8'h55, 1'b0);
      i_ctl.stop_cond();
      chk8(rd_ptr, 8'h23);
      i_ctl.start_cond();
      wb(8'hA5, 1'b1);
      repeat (2100) @(posedge clk);
      rb(8'hFF, 1'b0);
      i_ctl.stop_cond();
      // Backup supply while the acknowledge is driven
      i_ctl.start_cond();
      wb(8'hA4, 1'b1);
      backup <= 1'b1;
      @(negedge clk);
      chk1(dut_oe_n, 1'b1);
      repeat (2) @(negedge clk);
      chk8(rd_ptr, 8'h00);
      @(posedge clk);
      backup <= 1'b0;
      i_ctl.stop_cond();
      i_ctl.start_cond();
      wb(8'hA4, 1'b1);
      wb(8'h40, 1'b1);
      i_ctl.stop_cond();
      chk8(rd_ptr, 8'h40);
      // Backup supply with the bus at rest clears the pointer
      backup <= 1'b1;
      repeat (2) @(negedge clk);
      chk1(dut_oe_n, 1'b1);
      chk8(rd_ptr, 8'h00);
      @(posedge clk);
      backup <= 1'b0;
      // Reset while the pointer byte is acknowledged, then a plain read
      i_ctl.start_cond();
      wb(8'hA4, 1'b1);
      wb(8'h40, 1'b1);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk1(dut_oe_n, 1'b1);
      chk1(wr_valid, 1'b0);
      chk8(rd_ptr, 8'h00);
      repeat (3) @(posedge clk);
      i_ctl.stop_cond();
      i_ctl.start_cond();
      wb(8'hA5, 1'b1);
      rb(8'h5A, 1'b0);
      i_ctl.stop_cond();
      summarize();
   end

endmodule : testbench
